/* src/wtc_top.sv */
// Wake-up and sleep comparator with AXI4-Lite registers and alert pin.
`include "wtc_map.svh"

// Function
// - Command 0x28 captures present Z baseline.
// - Alert only when change strictly exceeds threshold.
// - Default mode: alert, baseline never changes.
// - Refresh mode: exceedance replaces baseline.
// - Adjacent select overrides refresh select.
// - Alert drops only after full data read.
// - Alert never self-clears when field returns.
// - Angle output forces non-updating baseline mode.
// - Angle output: plane threshold means angle.
// - Plane select: 0 XY, 1 YZ, 2 XZ, 3 XY.
// - Adjacent mode compares consecutive measurements.
// - Standby wait is interval times 20 ms.
module wtc_top #(
	parameter int unsigned STEP_CYCLES = `WTC_STEP_NS / `WTC_CLK_NS
) (
	// Clock and reset
	input  wire logic        I_CLK_SYS,
	input  wire logic        I_RESET_N,
	// AXI4-Lite write channels
	input  wire logic [7:0]  I_AXI_AWADDR,
	input  wire logic        I_AXI_AWVALID,
	output logic             O_AXI_AWREADY,
	input  wire logic [31:0] I_AXI_WDATA,
	input  wire logic [3:0]  I_AXI_WSTRB,
	input  wire logic        I_AXI_WVALID,
	output logic             O_AXI_WREADY,
	output logic [1:0]       O_AXI_BRESP,
	output logic             O_AXI_BVALID,
	input  wire logic        I_AXI_BREADY,
	// AXI4-Lite read channels
	input  wire logic [7:0]  I_AXI_ARADDR,
	input  wire logic        I_AXI_ARVALID,
	output logic             O_AXI_ARREADY,
	output logic [31:0]      O_AXI_RDATA,
	output logic [1:0]       O_AXI_RRESP,
	output logic             O_AXI_RVALID,
	input  wire logic        I_AXI_RREADY,
	// Measurement front end
	input  wire logic        I_MEAS_VALID,
	input  wire logic [15:0] I_MEAS_Z,
	input  wire logic [15:0] I_MEAS_PLANE,
	output logic             O_MEAS_REQ,
	output logic             O_ANGLE_MODE,
	output logic [1:0]       O_PLANE_SEL,
	// Alert and interrupt
	output logic             O_ALERT,
	output logic             O_IRQ
);
	////////////////////////////////////////////////////////////////////////////////
	logic                aw_have_q, aw_have_d, w_have_q, w_have_d;
	logic [7:0]          aw_addr_q, aw_addr_d;
	logic [31:0]         w_data_q, w_data_d;
	logic [3:0]          w_strb_q, w_strb_d;
	logic                bvalid_q, bvalid_d, rvalid_q, rvalid_d;
	logic [1:0]          bresp_q, bresp_d, rresp_q, rresp_d;
	logic [31:0]         rdata_q, rdata_d;
	logic [5:0]          interval_q, interval_d;
	logic                adj_q, adj_d, refr_q, refr_d, ang_q, ang_d;
	logic [1:0]          plane_q, plane_d, mask_q, mask_d;
	wtc_pkg::wtc_word_t  zth_q, zth_d, pth_q, pth_d;
	logic                do_wr, ar_hs, st_rd, frame_rd;
	logic [32:0]         wr_cur;
	logic [31:0]         wr_word;
	logic [32:0]         rd_view;
	wtc_pkg::wtc_state_t state_q, state_d;
	wtc_pkg::wtc_word_t  first_z_baseline_q, first_z_baseline_d, base_p_q, base_p_d;
	wtc_pkg::wtc_word_t  last_z_q, last_z_d, last_p_q, last_p_d;
	logic                alert_q, alert_d;
	logic [1:0]          status_q, status_d, plane_out_q, plane_out_d;
	logic                start, stop, meas_take, tmr_done, exc_z, exc_p, any_exc;
	logic                eff_adj, eff_refr, alert_set;

	// Read view of one register: bit 32 flags a mapped address.
	function automatic logic [32:0] wtc_view(input logic [7:0] a);
		logic [31:0] v;
		logic        ok;
		v  = 32'h0;
		ok = 1'b1;
		case (a)
			`WTC_OFF_MEAS_CFG: begin
				v[`WTC_INTERVAL_MSB:`WTC_INTERVAL_LSB] = interval_q;
				v[`WTC_ADJ_BIT] = adj_q;
			end
			`WTC_OFF_WAKE_CFG:  v[`WTC_REFRESH_BIT] = refr_q;
			`WTC_OFF_ANGLE_CFG: v[`WTC_ANGLE_BIT] = ang_q;
			`WTC_OFF_PLANE_CFG: v[`WTC_PLANE_MSB:`WTC_PLANE_LSB] = plane_q;
			`WTC_OFF_Z_TH:      v[15:0] = zth_q;
			`WTC_OFF_PLANE_TH:  v[15:0] = pth_q;
			`WTC_OFF_CMD:       v[0] = state_q != wtc_pkg::WTC_IDLE;
			`WTC_OFF_STATUS:    v[1:0] = status_q;
			`WTC_OFF_MASK:      v[1:0] = mask_q;
			`WTC_OFF_FRAME:     v = {last_p_q, last_z_q};
			`WTC_OFF_BASE:      v = {base_p_q, first_z_baseline_q};
			default:            ok = 1'b0;
		endcase
		wtc_view = {ok, v};
	endfunction : wtc_view

	function automatic logic [31:0] wtc_merge(input logic [31:0] old, input logic [31:0] wd,
	                                          input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (st[i]) begin
				r[8*i +: 8] = wd[8*i +: 8];
			end
		end
		wtc_merge = r;
	endfunction : wtc_merge

	assign O_AXI_AWREADY = !aw_have_q && !bvalid_q;
	assign O_AXI_WREADY  = !w_have_q && !bvalid_q;
	assign O_AXI_ARREADY = !rvalid_q;
	assign do_wr    = aw_have_q && w_have_q;
	assign ar_hs    = I_AXI_ARVALID && !rvalid_q;
	assign st_rd    = ar_hs && I_AXI_ARADDR == `WTC_OFF_STATUS;
	assign frame_rd = ar_hs && I_AXI_ARADDR == `WTC_OFF_FRAME;
	assign wr_cur   = wtc_view(aw_addr_q);
	assign wr_word  = wtc_merge(wr_cur[31:0], w_data_q, w_strb_q);
	assign rd_view  = wtc_view(I_AXI_ARADDR);

	always_comb begin
		aw_have_d  = aw_have_q;
		aw_addr_d  = aw_addr_q;
		w_have_d   = w_have_q;
		w_data_d   = w_data_q;
		w_strb_d   = w_strb_q;
		bvalid_d   = bvalid_q && !I_AXI_BREADY;
		bresp_d    = bresp_q;
		rvalid_d   = rvalid_q && !I_AXI_RREADY;
		rresp_d    = rresp_q;
		rdata_d    = rdata_q;
		interval_d = interval_q;
		adj_d      = adj_q;
		refr_d     = refr_q;
		ang_d      = ang_q;
		plane_d    = plane_q;
		zth_d      = zth_q;
		pth_d      = pth_q;
		mask_d     = mask_q;
		if (I_AXI_AWVALID && O_AXI_AWREADY) begin
			aw_have_d = 1'b1;
			aw_addr_d = I_AXI_AWADDR;
		end
		if (I_AXI_WVALID && O_AXI_WREADY) begin
			w_have_d = 1'b1;
			w_data_d = I_AXI_WDATA;
			w_strb_d = I_AXI_WSTRB;
		end
		if (do_wr) begin
			aw_have_d = 1'b0;
			w_have_d  = 1'b0;
			bvalid_d  = 1'b1;
			bresp_d   = wr_cur[32] ? `WTC_RESP_OKAY : `WTC_RESP_SLVERR;
			case (aw_addr_q)
				`WTC_OFF_MEAS_CFG: begin
					interval_d = wr_word[`WTC_INTERVAL_MSB:`WTC_INTERVAL_LSB];
					adj_d      = wr_word[`WTC_ADJ_BIT];
				end
				`WTC_OFF_WAKE_CFG:  refr_d  = wr_word[`WTC_REFRESH_BIT];
				`WTC_OFF_ANGLE_CFG: ang_d   = wr_word[`WTC_ANGLE_BIT];
				`WTC_OFF_PLANE_CFG: plane_d = wr_word[`WTC_PLANE_MSB:`WTC_PLANE_LSB];
				`WTC_OFF_Z_TH:      zth_d   = wr_word[15:0];
				`WTC_OFF_PLANE_TH:  pth_d   = wr_word[15:0];
				`WTC_OFF_MASK:      mask_d  = wr_word[1:0];
				default:            mask_d  = mask_q;
			endcase
		end
		if (ar_hs) begin
			rvalid_d = 1'b1;
			rdata_d  = rd_view[31:0];
			rresp_d  = rd_view[32] ? `WTC_RESP_OKAY : `WTC_RESP_SLVERR;
		end
	end

	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RESET_N) begin
			aw_have_q  <= 1'b0;
			aw_addr_q  <= 8'h00;
			w_have_q   <= 1'b0;
			w_data_q   <= 32'h0;
			w_strb_q   <= 4'h0;
			bvalid_q   <= 1'b0;
			bresp_q    <= `WTC_RESP_OKAY;
			rvalid_q   <= 1'b0;
			rresp_q    <= `WTC_RESP_OKAY;
			rdata_q    <= 32'h0;
			interval_q <= 6'h0;
			adj_q      <= 1'b0;
			refr_q     <= 1'b0;
			ang_q      <= 1'b0;
			plane_q    <= `WTC_PLANE_XY;
			zth_q      <= `WTC_RST_WORD;
			pth_q      <= `WTC_RST_WORD;
			mask_q     <= 2'h0;
		end else begin
			aw_have_q  <= aw_have_d;
			aw_addr_q  <= aw_addr_d;
			w_have_q   <= w_have_d;
			w_data_q   <= w_data_d;
			w_strb_q   <= w_strb_d;
			bvalid_q   <= bvalid_d;
			bresp_q    <= bresp_d;
			rvalid_q   <= rvalid_d;
			rresp_q    <= rresp_d;
			rdata_q    <= rdata_d;
			interval_q <= interval_d;
			adj_q      <= adj_d;
			refr_q     <= refr_d;
			ang_q      <= ang_d;
			plane_q    <= plane_d;
			zth_q      <= zth_d;
			pth_q      <= pth_d;
			mask_q     <= mask_d;
		end
	end

	assign O_AXI_BVALID = bvalid_q;
	assign O_AXI_BRESP  = bresp_q;
	assign O_AXI_RVALID = rvalid_q;
	assign O_AXI_RRESP  = rresp_q;
	assign O_AXI_RDATA  = rdata_q;

	////////////////////////////////////////////////////////////////////////////////
	// Planes 0 and 3 both select XY.
	function automatic logic [1:0] wtc_plane(input logic [1:0] s);
		case (s)
			2'h1:    wtc_plane = `WTC_PLANE_YZ;
			2'h2:    wtc_plane = `WTC_PLANE_XZ;
			default: wtc_plane = `WTC_PLANE_XY;
		endcase
	endfunction : wtc_plane

	assign start     = do_wr && aw_addr_q == `WTC_OFF_CMD && wr_word[7:0] == `WTC_CMD_WAKE;
	assign stop      = do_wr && aw_addr_q == `WTC_OFF_CMD && wr_word[7:0] != `WTC_CMD_WAKE;
	assign meas_take = state_q == wtc_pkg::WTC_MEAS && I_MEAS_VALID;
	assign eff_adj   = adj_q && !ang_q;
	assign eff_refr  = refr_q && !adj_q && !ang_q;
	assign any_exc   = exc_z || exc_p;
	assign alert_set = meas_take && any_exc;

	wtc_delta u_delta_z (
		.i_new    (I_MEAS_Z),
		.i_ref    (first_z_baseline_q),
		.i_th     (zth_q),
		.o_exceed (exc_z)
	);

	// With angle output the plane channel carries an angle, and its threshold is an angle.
	wtc_delta u_delta_p (
		.i_new    (I_MEAS_PLANE),
		.i_ref    (base_p_q),
		.i_th     (pth_q),
		.o_exceed (exc_p)
	);

	wtc_interval_timer #(
		.STEP_CYCLES (STEP_CYCLES)
	) u_timer (
		.i_clk      (I_CLK_SYS),
		.i_reset_n  (I_RESET_N),
		.i_start    (start || meas_take),
		.i_interval (interval_q),
		.o_done     (tmr_done)
	);

	always_comb begin
		state_d            = state_q;
		first_z_baseline_d = first_z_baseline_q;
		base_p_d           = base_p_q;
		last_z_d           = I_MEAS_VALID ? I_MEAS_Z : last_z_q;
		last_p_d           = I_MEAS_VALID ? I_MEAS_PLANE : last_p_q;
		plane_out_d        = wtc_plane(plane_q);
		case (state_q)
			wtc_pkg::WTC_IDLE: state_d = wtc_pkg::WTC_IDLE;
			wtc_pkg::WTC_WAIT: state_d = tmr_done ? wtc_pkg::WTC_MEAS : wtc_pkg::WTC_WAIT;
			wtc_pkg::WTC_MEAS: state_d = meas_take ? wtc_pkg::WTC_WAIT : wtc_pkg::WTC_MEAS;
			default:           state_d = wtc_pkg::WTC_IDLE;
		endcase
		// Adjacent mode keeps the previous sample in the baseline registers.
		if (meas_take && (eff_adj || (eff_refr && any_exc))) begin
			first_z_baseline_d = I_MEAS_Z;
			base_p_d           = I_MEAS_PLANE;
		end
		if (stop) begin
			state_d = wtc_pkg::WTC_IDLE;
		end
		if (start) begin
			state_d            = wtc_pkg::WTC_WAIT;
			first_z_baseline_d = last_z_q;
			base_p_d           = last_p_q;
		end
		// A new exceedance in the read cycle keeps the alert high.
		alert_d  = alert_set || (alert_q && !frame_rd);
		status_d = (st_rd ? 2'h0 : status_q) | {meas_take, alert_set};
	end

	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RESET_N) begin
			state_q            <= wtc_pkg::WTC_IDLE;
			first_z_baseline_q <= `WTC_RST_WORD;
			base_p_q           <= `WTC_RST_WORD;
			last_z_q           <= `WTC_RST_WORD;
			last_p_q           <= `WTC_RST_WORD;
			alert_q            <= 1'b0;
			status_q           <= 2'h0;
			plane_out_q        <= `WTC_PLANE_XY;
		end else begin
			state_q            <= state_d;
			first_z_baseline_q <= first_z_baseline_d;
			base_p_q           <= base_p_d;
			last_z_q           <= last_z_d;
			last_p_q           <= last_p_d;
			alert_q            <= alert_d;
			status_q           <= status_d;
			plane_out_q        <= plane_out_d;
		end
	end

	assign O_MEAS_REQ   = state_q == wtc_pkg::WTC_WAIT && tmr_done;
	assign O_ANGLE_MODE = ang_q;
	assign O_PLANE_SEL  = plane_out_q;
	assign O_ALERT      = alert_q;
	assign O_IRQ        = |(status_q & mask_q);

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge I_CLK_SYS); endclocking
	default disable iff (!I_RESET_N);

	sequence s_exceed_take;
		meas_take && any_exc && !start;
	endsequence
	sequence s_quiet_take;
		meas_take && !any_exc && !start;
	endsequence

	a_alert_sticky: assert property (alert_q && !frame_rd |=> alert_q)
		else $error("alert dropped without a frame read");
	a_alert_clear: assert property (alert_q && frame_rd && !alert_set |=> !alert_q)
		else $error("alert stayed high after a frame read");
	a_alert_cause: assert property ($rose(alert_q) |-> $past(meas_take && any_exc))
		else $error("alert rose without an exceedance");
	a_base_fixed: assert property (s_quiet_take |=> first_z_baseline_q == $past(first_z_baseline_q)
	                               || $past(eff_adj))
		else $error("baseline moved without exceedance");
	a_base_hold: assert property (s_exceed_take ##0 !eff_adj && !eff_refr
	                              |=> $stable(first_z_baseline_q))
		else $error("baseline moved in non-updating mode");
	a_base_refresh: assert property (s_exceed_take ##0 eff_refr
	                                 |=> first_z_baseline_q == $past(I_MEAS_Z))
		else $error("baseline not refreshed on exceedance");
	a_adj_track: assert property (meas_take && eff_adj && !start
	                              |=> first_z_baseline_q == $past(I_MEAS_Z))
		else $error("adjacent mode did not keep the last sample");
	a_start_capture: assert property (start |=> first_z_baseline_q == $past(last_z_q)
	                                  && state_q == wtc_pkg::WTC_WAIT)
		else $error("start did not capture the baseline");
	a_angle_mode: assert property (ang_q |-> !eff_adj && !eff_refr)
		else $error("angle output allowed an updating mode");
	a_plane_map: assert property (plane_q == 2'h3 |=> O_PLANE_SEL == `WTC_PLANE_XY)
		else $error("plane code three did not select XY");
	a_req_timed: assert property (O_MEAS_REQ |=> state_q == wtc_pkg::WTC_MEAS || $past(start || stop))
		else $error("measurement request outside the wait state");
endmodule : wtc_top

/* src/wtc_map.svh */
// Register offsets, field positions, codes and timing figures of the wake comparator.
`ifndef WTC_MAP_SVH
`define WTC_MAP_SVH
`define WTC_OFF_MEAS_CFG  8'h00
`define WTC_OFF_WAKE_CFG  8'h04
`define WTC_OFF_ANGLE_CFG 8'h08
`define WTC_OFF_PLANE_CFG 8'h0C
`define WTC_OFF_Z_TH      8'h10
`define WTC_OFF_PLANE_TH  8'h14
`define WTC_OFF_CMD       8'h18
`define WTC_OFF_STATUS    8'h1C
`define WTC_OFF_MASK      8'h20
`define WTC_OFF_FRAME     8'h24
`define WTC_OFF_BASE      8'h28
`define WTC_INTERVAL_MSB  5
`define WTC_INTERVAL_LSB  0
`define WTC_ADJ_BIT       11
`define WTC_REFRESH_BIT   13
`define WTC_ANGLE_BIT     15
`define WTC_PLANE_MSB     15
`define WTC_PLANE_LSB     14
`define WTC_CMD_WAKE      8'h28
`define WTC_ST_ALERT      0
`define WTC_ST_MEAS       1
`define WTC_RESP_OKAY     2'h0
`define WTC_RESP_SLVERR   2'h2
`define WTC_PLANE_XY      2'h0
`define WTC_PLANE_YZ      2'h1
`define WTC_PLANE_XZ      2'h2
`define WTC_RST_WORD      16'h0000
`define WTC_STEP_NS       20000000
`define WTC_CLK_NS        5
`endif

/* src/wtc_pkg.sv */
// Shared types of the wake comparator.
package wtc_pkg;
	typedef logic [15:0] wtc_word_t;
	// Gray coded: idle, waiting out the standby interval, awaiting a result.
	typedef enum logic [1:0] {
		WTC_IDLE = 2'h0,
		WTC_WAIT = 2'h1,
		WTC_MEAS = 2'h3
	} wtc_state_t;
endpackage : wtc_pkg

/* src/wtc_delta.sv */
// Magnitude comparison of one measured channel against its reference.
module wtc_delta (
	// Operands
	input  wire logic [15:0] i_new,
	input  wire logic [15:0] i_ref,
	input  wire logic [15:0] i_th,
	// Result
	output logic             o_exceed
);
	// Samples are two's complement, so the difference needs a seventeenth bit.
	function automatic logic [16:0] wtc_abs_diff(input logic [15:0] a, input logic [15:0] b);
		logic signed [16:0] d;
		d = $signed({a[15], a}) - $signed({b[15], b});
		wtc_abs_diff = d[16] ? 17'(-d) : 17'(d);
	endfunction : wtc_abs_diff

	// Equality with the threshold does not trip; rise and fall both count.
	assign o_exceed = wtc_abs_diff(i_new, i_ref) > {1'b0, i_th};
endmodule : wtc_delta

/* src/wtc_interval_timer.sv */
// Standby interval counter: a number of fixed steps between two measurements.
module wtc_interval_timer #(
	parameter int unsigned STEP_CYCLES = 4
) (
	// Clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_reset_n,
	// Control
	input  wire logic       i_start,
	input  wire logic [5:0] i_interval,
	// Status
	output logic            o_done
);
	logic [5:0]  steps_q;
	logic [5:0]  steps_d;
	logic [31:0] cyc_q;
	logic [31:0] cyc_d;
	logic        run_q;
	logic        run_d;

	always_comb begin
		steps_d = steps_q;
		cyc_d   = cyc_q;
		run_d   = run_q;
		if (i_start) begin
			steps_d = i_interval;
			cyc_d   = 32'h0;
			run_d   = 1'b1;
		end else if (run_q && steps_q != 6'h0) begin
			if (cyc_q == 32'(STEP_CYCLES - 1)) begin
				cyc_d   = 32'h0;
				steps_d = steps_q - 6'h1;
			end else begin
				cyc_d = cyc_q + 32'h1;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			steps_q <= 6'h0;
			cyc_q   <= 32'h0;
			run_q   <= 1'b0;
		end else begin
			steps_q <= steps_d;
			cyc_q   <= cyc_d;
			run_q   <= run_d;
		end
	end

	// Stays high until the next start; an interval of zero is done at once.
	assign o_done = run_q && steps_q == 6'h0 && !i_start;
endmodule : wtc_interval_timer

/* dv/wtc_front_model.sv */
// Measurement front end model that answers each request with one sample.
module wtc_front_model (
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_reset_n,
	// Control from the bench
	input  wire logic        i_req,
	input  wire logic        i_kick,
	input  wire logic [3:0]  i_delay,
	input  wire logic [15:0] i_z,
	input  wire logic [15:0] i_plane,
	// Sample towards the block
	output logic             o_valid,
	output logic [15:0]      o_z,
	output logic [15:0]      o_plane
);
	timeunit 1ns;
	timeprecision 1ps;
	int   cnt;
	logic fire;

	assign fire = !(i_req || i_kick) && cnt == 0;

	// Data toggles outside a sample so a stale value never passes for a fresh one.
	always @(posedge i_clk) begin
		if (!i_reset_n) begin
			o_valid <= 1'b0;
			cnt     <= -1;
			o_z     <= 16'hA5A5;
			o_plane <= 16'h5A5A;
		end else begin
			o_valid <= fire;
			o_z     <= fire ? i_z : ~o_z;
			o_plane <= fire ? i_plane : ~o_plane;
			if (i_req || i_kick) begin
				cnt <= int'(i_delay);
			end else if (cnt >= 0) begin
				cnt <= cnt - 1;
			end
		end
	end
endmodule : wtc_front_model

/* dv/tb_wtc_top.sv */
// Self-checking bench of the wake comparator.
`include "wtc_map.svh"
module tb_wtc_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned STEP = 4;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  awaddr = 8'h00;
	logic [7:0]  araddr = 8'h00;
	logic        awvalid = 1'b0;
	logic        wvalid = 1'b0;
	logic        arvalid = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	logic [1:0]  bresp;
	logic [1:0]  rresp;
	logic        awready;
	logic        wready;
	logic        bvalid;
	logic        arready;
	logic        rvalid;
	logic        m_valid;
	logic        m_req;
	logic        ang;
	logic        alert;
	logic        irq;
	logic        kick = 1'b0;
	logic [15:0] m_z;
	logic [15:0] m_pl;
	logic [15:0] z = 16'h0;
	logic [15:0] pl = 16'h0;
	logic [15:0] v;
	logic [3:0]  dly = 4'h1;
	logic [1:0]  psel;
	logic [31:0] rd;
	logic [1:0]  rs;
	logic [1:0]  bs;
	logic [3:0]  strb = 4'hF;
	int          error_cnt = 0;
	int          check_count = 0;
	int          seed = 35358;
	int          p0;
	int          p3;

	wtc_top #(.STEP_CYCLES(STEP)) i_wtc_top (.I_CLK_SYS(clk), .I_RESET_N(rst_n), .I_AXI_AWADDR(awaddr),
		.I_AXI_AWVALID(awvalid), .O_AXI_AWREADY(awready), .I_AXI_WDATA(wdata), .I_AXI_WSTRB(strb),
		.I_AXI_WVALID(wvalid), .O_AXI_WREADY(wready), .O_AXI_BRESP(bresp), .O_AXI_BVALID(bvalid),
		.I_AXI_BREADY(1'b1), .I_AXI_ARADDR(araddr), .I_AXI_ARVALID(arvalid), .O_AXI_ARREADY(arready),
		.O_AXI_RDATA(rdata), .O_AXI_RRESP(rresp), .O_AXI_RVALID(rvalid), .I_AXI_RREADY(1'b1),
		.I_MEAS_VALID(m_valid), .I_MEAS_Z(m_z), .I_MEAS_PLANE(m_pl), .O_MEAS_REQ(m_req),
		.O_ANGLE_MODE(ang), .O_PLANE_SEL(psel), .O_ALERT(alert), .O_IRQ(irq));
	wtc_front_model i_wtc_front_model (.i_clk(clk), .i_reset_n(rst_n), .i_req(m_req), .i_kick(kick),
		.i_delay(dly), .i_z(z), .i_plane(pl), .o_valid(m_valid), .o_z(m_z), .o_plane(m_pl));

	////////////////////////////////////////
	task automatic end_of_test();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : end_of_test

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	function automatic logic hit(input logic [15:0] n, input logic [15:0] r, input logic [15:0] th);
		int d;
		d = int'($signed(n)) - int'($signed(r));
		return ((d < 0) ? -d : d) > int'(th);
	endfunction : hit

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge clk);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge clk);
			if (awready && awvalid) begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (wready && wvalid) begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do begin
			@(posedge clk);
		end while (!bvalid);
		bs = bresp;
	endtask : wr

	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		araddr  <= a;
		arvalid <= 1'b1;
		do @(posedge clk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge clk); while (!rvalid);
		d = rdata;
		r = rresp;
	endtask : rd_reg

	// Waits up to 300 clocks for the first valid pulse after the change, then one more clock.
	task automatic smp(input logic [15:0] zz, input logic [15:0] pp);
		@(posedge clk);
		z   <= zz;
		pl  <= pp;
		dly <= 4'($random(seed) & 3);
		@(posedge clk);
		for (int i = 0; i < 300; i++) begin
			@(posedge clk);
			if (m_valid) break;
		end
		@(posedge clk);
		#1;
	endtask : smp

	task automatic start(input logic [31:0] mc, input logic [31:0] wc, input logic [31:0] ac,
		input logic [15:0] zth, input logic [15:0] pth, input logic [15:0] bz, input logic [15:0] bp);
		wr(`WTC_OFF_CMD, 32'h0);
		wr(`WTC_OFF_MEAS_CFG, mc);
		wr(`WTC_OFF_WAKE_CFG, wc);
		wr(`WTC_OFF_ANGLE_CFG, ac);
		wr(`WTC_OFF_Z_TH, {16'h0, zth});
		wr(`WTC_OFF_PLANE_TH, {16'h0, pth});
		z  <= bz;
		pl <= bp;
		@(posedge clk);
		kick <= 1'b1;
		@(posedge clk);
		kick <= 1'b0;
		repeat (8) @(posedge clk);
		wr(`WTC_OFF_CMD, 32'h28);
		rd_reg(`WTC_OFF_BASE, rd, rs);
		chk("start baseline", {bp, bz}, rd);
		rd_reg(`WTC_OFF_FRAME, rd, rs);
	endtask : start

	task automatic period(input logic [5:0] n, output int p);
		dly <= 4'h1;
		wr(`WTC_OFF_CMD, 32'h0);
		wr(`WTC_OFF_MEAS_CFG, {26'h0, n});
		wr(`WTC_OFF_CMD, 32'h28);
		p = 0;
		for (int i = 0; i < 500 && !m_req; i++) @(posedge clk);
		do begin
			@(posedge clk);
			p++;
		end while (!m_req && p < 500);
	endtask : period

	////////////////////////////////////////
	initial begin
		forever #2.5 clk = ~clk;
	end

	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		end_of_test();
	end

	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		rd_reg(`WTC_OFF_Z_TH, rd, rs);
		chk("z threshold reset", 32'h0, rd);
		rd_reg(8'h30, rd, rs);
		chk("unmapped resp", {30'h0, `WTC_RESP_SLVERR}, {30'h0, rs});
		wr(8'h30, 32'h0);
		chk("unmapped write resp", {30'h0, `WTC_RESP_SLVERR}, {30'h0, bs});
		wr(`WTC_OFF_Z_TH, 32'h1234);
		strb <= 4'h1;
		wr(`WTC_OFF_Z_TH, 32'hABCD);
		strb <= 4'hF;
		chk("strobe write resp", {30'h0, `WTC_RESP_OKAY}, {30'h0, bs});
		rd_reg(`WTC_OFF_Z_TH, rd, rs);
		chk("strobe merge", 32'h12CD, rd);
		for (int i = 0; i < 4; i++) begin
			wr(`WTC_OFF_PLANE_CFG, 32'(i) << 14);
			#1;
			chk("plane select", 32'((i == 3) ? 0 : i), {30'h0, psel});
		end
		wr(`WTC_OFF_MASK, 32'h1);
		start(32'h0, 32'h0, 32'h0, 16'h0064, 16'h7FFF, 16'h03E8, 16'h0000);
		smp(16'h044C, 16'h0000);
		chk("alert at equal", 32'h0, {31'h0, alert});
		smp(16'h0383, 16'h0000);
		chk("alert on drop", 32'h1, {31'h0, alert});
		chk("irq on alert", 32'h1, {31'h0, irq});
		smp(16'h03E8, 16'h0000);
		chk("alert held", 32'h1, {31'h0, alert});
		rd_reg(`WTC_OFF_BASE, rd, rs);
		chk("fixed baseline", 32'h03E8, rd);
		rd_reg(`WTC_OFF_STATUS, rd, rs);
		chk("status bits", 32'h3, {30'h0, rd[1:0]});
		@(posedge clk);
		#1;
		chk("irq after status read", 32'h0, {31'h0, irq});
		rd_reg(`WTC_OFF_FRAME, rd, rs);
		chk("frame z", 32'h03E8, {16'h0, rd[15:0]});
		@(posedge clk);
		#1;
		chk("alert after frame read", 32'h0, {31'h0, alert});
		for (int i = 0; i < 8; i++) begin
			v = 16'(1000 + $random(seed) % 160);
			smp(v, 16'h0000);
			chk("random alert", {31'h0, hit(v, 16'h03E8, 16'h0064)}, {31'h0, alert});
			smp(16'h03E8, 16'h0000);
			rd_reg(`WTC_OFF_FRAME, rd, rs);
		end
		start(32'h0, 32'h2000, 32'h0, 16'h0064, 16'h7FFF, 16'h03E8, 16'h0000);
		smp(16'h04B0, 16'h0000);
		chk("refresh alert", 32'h1, {31'h0, alert});
		smp(16'h04C4, 16'h0000);
		rd_reg(`WTC_OFF_BASE, rd, rs);
		chk("refreshed baseline", 32'h04B0, rd);
		start(32'h0800, 32'h2000, 32'h0, 16'h0064, 16'h7FFF, 16'h03E8, 16'h0000);
		smp(16'h041A, 16'h0000);
		rd_reg(`WTC_OFF_BASE, rd, rs);
		chk("adjacent baseline", 32'h041A, rd);
		smp(16'h0488, 16'h0000);
		chk("adjacent alert", 32'h1, {31'h0, alert});
		start(32'h0800, 32'h2000, 32'h8000, 16'h7FFF, 16'h0032, 16'h03E8, 16'h012C);
		chk("angle mode pin", 32'h1, {31'h0, ang});
		smp(16'h03E8, 16'h0168);
		chk("angle alert", 32'h1, {31'h0, alert});
		rd_reg(`WTC_OFF_BASE, rd, rs);
		chk("angle baseline", 32'h012C03E8, rd);
		period(6'h00, p0);
		period(6'h03, p3);
		chk("interval length", 32'(3 * STEP), 32'(p3 - p0));
		end_of_test();
	end
endmodule : tb_wtc_top
